// ---- src/sww_top.sv ----
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
module sww_top import sww_pkg::*; #(
   parameter int WAIT_8192 = SWW_WAIT_8192,
   parameter int WAIT_16384 = SWW_WAIT_16384,
   parameter int WAIT_32768 = SWW_WAIT_32768,
   parameter int WAIT_65536 = SWW_WAIT_65536,
   parameter int WAIT_131072 = SWW_WAIT_131072,
   parameter int WAIT_262144 = SWW_WAIT_262144
) (
   input wire logic CLOCK,
   input wire logic RESET,
   input wire logic [SWW_AXI_AW-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [SWW_AXI_AW-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic STANDBY_ENTER,
   input wire logic [1:0] STANDBY_KIND,
   input wire logic EXT_WAKE,
   output logic CLOCK_RUN,
   output logic BUS_HIZ,
   output logic WAKE_DONE
);
   localparam sww_top_s RST = '{
      awready: 1'b1, wready: 1'b1, arready: 1'b1,
      wake_wait_sel: SWW_SEL_RESET, bus_output_hold: SWW_HOLD_RESET,
      state: SWW_ST_RUN, kind: SWW_K_SOFT, clock_run: 1'b1,
      default: '0};

   sww_top_s q;
   sww_top_s d;
   logic wait_zero;
   logic wait_load;
   logic [SWW_CNT_W-1:0] wait_value;

   // Refuses, at elaboration, wait counts that are zero or overflow the wait counter.
   if (WAIT_262144 < 1 || WAIT_262144 >= (1 << SWW_CNT_W) || WAIT_8192 < 1 ||
       WAIT_16384 < 1 || WAIT_32768 < 1 || WAIT_65536 < 1 || WAIT_131072 < 1 ||
       WAIT_8192 >= (1 << SWW_CNT_W) || WAIT_16384 >= (1 << SWW_CNT_W) ||
       WAIT_32768 >= (1 << SWW_CNT_W) || WAIT_65536 >= (1 << SWW_CNT_W) ||
       WAIT_131072 >= (1 << SWW_CNT_W)) begin : g_bad_wait
      $error("sww_top: wait counts must fit the wait counter");
   end

   // Maps the wait-select code onto the number of settle states.
   function automatic logic [SWW_CNT_W-1:0] wait_states(input logic [2:0] sel);
      logic [SWW_CNT_W-1:0] n;
      unique case (sel)
         3'h0: n = SWW_CNT_W'(WAIT_8192);
         3'h1: n = SWW_CNT_W'(WAIT_16384);
         3'h2: n = SWW_CNT_W'(WAIT_32768);
         3'h3: n = SWW_CNT_W'(WAIT_65536);
         3'h4: n = SWW_CNT_W'(WAIT_131072);
         3'h5: n = SWW_CNT_W'(WAIT_262144);
         3'h6: n = SWW_WAIT_2048;
         3'h7: n = SWW_WAIT_16;
      endcase
      return n;
   endfunction : wait_states

   assign wait_load = (q.state == SWW_ST_STBY) && EXT_WAKE;
   assign wait_value = wait_states(q.wake_wait_sel);

   always_comb begin
      d = q;
      d.wake_done = 1'b0;
      if (S_AXI_AWVALID && q.awready) begin
         d.aw_got = 1'b1;
         d.awaddr = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && q.wready) begin
         d.w_got = 1'b1;
         d.wdata = S_AXI_WDATA;
         d.wstrb = S_AXI_WSTRB;
      end
      if (q.bvalid && S_AXI_BREADY) begin
         d.bvalid = 1'b0;
      end
      if (d.aw_got && d.w_got && !d.bvalid) begin
         d.aw_got = 1'b0;
         d.w_got = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = SWW_RESP_OKAY;
         if (d.awaddr == SWW_CTRL_OFS) begin
            if (d.wstrb[0]) begin
               // Bits 2 down to 0 and bit 7 have no storage.
               d.wake_wait_sel = d.wdata[SWW_SEL_LSB +: 3];
               d.bus_output_hold = d.wdata[SWW_HOLD_BIT];
            end
         end else if (d.awaddr != SWW_STAT_OFS) begin
            d.bresp = SWW_RESP_SLVERR;
         end
      end
      d.awready = !d.aw_got && !d.bvalid;
      d.wready = !d.w_got && !d.bvalid;

      if (q.rvalid && S_AXI_RREADY) begin
         d.rvalid = 1'b0;
      end
      if (S_AXI_ARVALID && q.arready) begin
         d.rvalid = 1'b1;
         d.rdata = '0;
         d.rresp = SWW_RESP_OKAY;
         if (S_AXI_ARADDR == SWW_CTRL_OFS) begin
            d.rdata[SWW_SEL_LSB +: 3] = q.wake_wait_sel;
            d.rdata[SWW_HOLD_BIT] = q.bus_output_hold;
         end else if (S_AXI_ARADDR == SWW_STAT_OFS) begin
            d.rdata[SWW_STAT_STATE_LSB +: 2] = q.state;
            d.rdata[SWW_STAT_KIND_LSB +: 2] = q.kind;
         end else begin
            d.rresp = SWW_RESP_SLVERR;
         end
      end
      d.arready = !d.rvalid;

      unique case (q.state)
         SWW_ST_RUN: begin
            if (STANDBY_ENTER) begin
               d.state = SWW_ST_STBY;
               d.kind = sww_kind_e'(STANDBY_KIND);
            end
         end
         SWW_ST_STBY: begin
            if (EXT_WAKE) begin
               d.state = SWW_ST_WAIT;
            end
         end
         SWW_ST_WAIT: begin
            if (wait_zero) begin
               d.state = SWW_ST_RUN;
               d.wake_done = 1'b1;
            end
         end
         default: d.state = SWW_ST_RUN;
      endcase
      d.clock_run = (d.state == SWW_ST_RUN);
      // Subactive keeps the bus alive; the other low-power kinds follow the hold bit.
      d.bus_hiz = (d.state != SWW_ST_RUN) && (d.kind != SWW_K_SUBACT) &&
                  !d.bus_output_hold;
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         q <= RST;
      end else begin
         q <= d;
      end
   end

   sww_wait_count #(.CNT_W(SWW_CNT_W)) u_wait (
      .clock(CLOCK),
      .reset(RESET),
      .load(wait_load),
      .load_value(wait_value),
      .zero(wait_zero)
   );

   assign S_AXI_AWREADY = q.awready;
   assign S_AXI_WREADY = q.wready;
   assign S_AXI_BVALID = q.bvalid;
   assign S_AXI_BRESP = q.bresp;
   assign S_AXI_ARREADY = q.arready;
   assign S_AXI_RVALID = q.rvalid;
   assign S_AXI_RDATA = q.rdata;
   assign S_AXI_RRESP = q.rresp;
   assign CLOCK_RUN = q.clock_run;
   assign BUS_HIZ = q.bus_hiz;
   assign WAKE_DONE = q.wake_done;

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RESET);

   sequence s_short_wake;
      q.state == SWW_ST_STBY && EXT_WAKE && q.wake_wait_sel == 3'h7;
   endsequence
   sequence s_gated_then_run;
      (!CLOCK_RUN) [*8] ##1 (!CLOCK_RUN) [*8] ##1 !CLOCK_RUN ##1 CLOCK_RUN;
   endsequence

   a_short_wait_len: assert property (s_short_wake |=> s_gated_then_run)
      else $error("16-state wake did not release after 17 gated cycles");
   a_wake_gated: assert property (q.state == SWW_ST_STBY && EXT_WAKE |=>
      !CLOCK_RUN [*2])
      else $error("clock released too early after wake");
   a_release_pulse: assert property ($rose(CLOCK_RUN) |-> WAKE_DONE && $past(wait_zero))
      else $error("clock released without count reaching zero");
   a_bus_float: assert property (BUS_HIZ == (!CLOCK_RUN && q.kind != SWW_K_SUBACT &&
      !q.bus_output_hold))
      else $error("bus float does not follow hold bit and mode");
   a_rsvd_zero: assert property (S_AXI_RVALID |-> S_AXI_RDATA[2:0] == 3'h0)
      else $error("reserved control bits read nonzero");
   a_sel_written: assert property ($rose(S_AXI_BVALID) && S_AXI_BRESP == SWW_RESP_OKAY &&
      q.awaddr == SWW_CTRL_OFS && q.wstrb[0] |->
      q.wake_wait_sel == q.wdata[SWW_SEL_LSB +: 3] &&
      q.bus_output_hold == q.wdata[SWW_HOLD_BIT])
      else $error("wait select not written");
endmodule : sww_top

// ---- src/sww_pkg.sv ----
// Contract
// - External-interrupt wake from standby, watch or subactive waits the selected settle time.
// - Wait-select codes 000..111 give 8192,16384,32768,65536,131072,262144,2048,16 states.
// - Bus outputs float in standby, watch or direct transition unless hold bit is 1.
// - Control bits 2 down to 0 always read zero and ignore writes.
package sww_pkg;
   localparam int SWW_AXI_AW = 4;
   localparam logic [SWW_AXI_AW-1:0] SWW_CTRL_OFS = 4'h0;
   localparam logic [SWW_AXI_AW-1:0] SWW_STAT_OFS = 4'h4;
   localparam int SWW_SEL_LSB = 4;
   localparam int SWW_HOLD_BIT = 3;
   localparam int SWW_STAT_STATE_LSB = 8;
   localparam int SWW_STAT_KIND_LSB = 10;
   localparam logic [2:0] SWW_SEL_RESET = 3'h0;
   localparam logic SWW_HOLD_RESET = 1'b1;
   localparam int SWW_CNT_W = 19;
   localparam int SWW_WAIT_8192 = 8192;
   localparam int SWW_WAIT_16384 = 16384;
   localparam int SWW_WAIT_32768 = 32768;
   localparam int SWW_WAIT_65536 = 65536;
   localparam int SWW_WAIT_131072 = 131072;
   localparam int SWW_WAIT_262144 = 262144;
   localparam logic [SWW_CNT_W-1:0] SWW_WAIT_2048 = 19'h00800;
   localparam logic [SWW_CNT_W-1:0] SWW_WAIT_16 = 19'h00010;
   localparam logic [1:0] SWW_RESP_OKAY = 2'h0;
   localparam logic [1:0] SWW_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      SWW_ST_RUN = 2'b00,
      SWW_ST_STBY = 2'b01,
      SWW_ST_WAIT = 2'b10
   } sww_state_e;

   typedef enum logic [1:0] {
      SWW_K_SOFT = 2'b00,
      SWW_K_WATCH = 2'b01,
      SWW_K_SUBACT = 2'b10,
      SWW_K_DIRECT = 2'b11
   } sww_kind_e;

   typedef struct packed {
      logic aw_got;
      logic w_got;
      logic [SWW_AXI_AW-1:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [2:0] wake_wait_sel;
      logic bus_output_hold;
      sww_state_e state;
      sww_kind_e kind;
      logic clock_run;
      logic bus_hiz;
      logic wake_done;
   } sww_top_s;

   typedef struct packed {
      logic [SWW_CNT_W-1:0] cnt;
   } sww_cnt_s;
endpackage : sww_pkg

// ---- src/sww_wait_count.sv ----
`timescale 1ns/100ps
module sww_wait_count import sww_pkg::*; #(
   parameter int CNT_W = SWW_CNT_W
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic load,
   input wire logic [CNT_W-1:0] load_value,
   output logic zero
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
   } sww_wc_s;

   sww_wc_s q;
   sww_wc_s d;

   // Refuses, at elaboration, a counter too narrow to count down at all.
   if (CNT_W < 2) begin : g_bad_width
      $error("sww_wait_count: CNT_W too small");
   end

   always_comb begin
      d = q;
      if (load) begin
         d.cnt = load_value;
      end else if (q.cnt != '0) begin
         d.cnt = q.cnt - 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign zero = (q.cnt == '0);

   a_load_takes: assert property (@(posedge clock) disable iff (reset)
      load |=> q.cnt == $past(load_value))
      else $error("wait counter did not take load value");
endmodule : sww_wait_count

// ---- sim/testbench.sv ----
`timescale 1ns/100ps
module testbench import sww_pkg::*;;
   localparam int W0 = 20;
   localparam int W1 = 24;
   localparam int W2 = 28;
   localparam int W3 = 32;
   localparam int W4 = 36;
   localparam int W5 = 40;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic [3:0] awaddr = 4'h0;
   logic [3:0] araddr = 4'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic enter = 1'b0;
   logic wake = 1'b0;
   logic [1:0] kind = 2'h0;
   logic awready, wready, bvalid, arready, rvalid, clock_run, bus_hiz, wake_done;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int err_count = 0;
   int cmp_count = 0;

   sww_top #(.WAIT_8192(W0), .WAIT_16384(W1), .WAIT_32768(W2), .WAIT_65536(W3),
      .WAIT_131072(W4), .WAIT_262144(W5)) i_sww_top (
      .CLOCK(clock), .RESET(reset), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
      .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .STANDBY_ENTER(enter), .STANDBY_KIND(kind), .EXT_WAKE(wake),
      .CLOCK_RUN(clock_run), .BUS_HIZ(bus_hiz), .WAKE_DONE(wake_done)
   );

   // The bench clock never changes source, so no switchover falls outside standby.
   initial begin
      forever #2.5 clock = ~clock;
   end

   function automatic int wlen(input int s);
      case (s)
         0: return W0;
         1: return W1;
         2: return W2;
         3: return W3;
         4: return W4;
         5: return W5;
         6: return 32'h800;
         default: return 32'h10;
      endcase
   endfunction : wlen

   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         err_count++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   task summarize;
      $display("mismatches %0d compares %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : summarize

   task axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clock);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge clock);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      r = bresp;
      bready <= 1'b0;
   endtask : axw

   task axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge clock);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axr

   initial begin
      logic [31:0] d, v;
      logic [1:0] r, k;
      int n;
      void'($urandom(19));
      repeat (10) @(posedge clock);
      reset <= 1'b0;
      axr(SWW_CTRL_OFS, d, r);
      chk("ctrl reset", d, 32'h08);
      axw(4'h8, 32'hFF, r);
      chk("bresp unmapped", r, SWW_RESP_SLVERR);
      axr(4'h8, d, r);
      chk("rresp unmapped", r, SWW_RESP_SLVERR);
      axw(SWW_STAT_OFS, 32'hFF, r);
      chk("bresp status", r, SWW_RESP_OKAY);
      axr(SWW_CTRL_OFS, d, r);
      chk("ctrl kept", d, 32'h08);
      wstrb <= 4'hE;
      axw(SWW_CTRL_OFS, 32'h77, r);
      wstrb <= 4'hF;
      chk("bresp strobe", r, SWW_RESP_OKAY);
      axr(SWW_CTRL_OFS, d, r);
      chk("ctrl strobe", d, 32'h08);
      // Every wait code once, random kind, hold bit and filler bits.
      // The bench models a crystal-clocked part, so the 16-state code is allowed.
      for (int s = 0; s < 8; s++) begin
         v = $urandom;
         v[6:4] = s[2:0];
         k = 2'($urandom_range(3));
         axw(SWW_CTRL_OFS, v, r);
         axr(SWW_CTRL_OFS, d, r);
         chk("ctrl read", d, v & 32'h78);
         @(posedge clock);
         wake <= 1'b1;
         @(posedge clock);
         wake <= 1'b0;
         enter <= 1'b1;
         kind <= k;
         #1 chk("wake in run", clock_run, 32'h1);
         @(posedge clock);
         enter <= 1'b0;
         #1 chk("gated", clock_run, 32'h0);
         chk("float", bus_hiz, 32'(!v[3] && k != 2'h2));
         axr(SWW_STAT_OFS, d, r);
         chk("status", d[11:8], {k, 2'h1});
         @(posedge clock);
         wake <= 1'b1;
         @(posedge clock);
         wake <= 1'b0;
         n = 0;
         do begin
            @(posedge clock);
            #1 n++;
         end while (clock_run !== 1'b1 && n < 3000);
         chk("wait len", n, wlen(s) + 1);
         chk("wake done", wake_done, 32'h1);
         chk("float off", bus_hiz, 32'h0);
      end
      summarize();
   end

   initial begin
      repeat (30000) @(posedge clock);
      err_count++;
      summarize();
   end
endmodule : testbench
